// *** design/seq_pkg.sv ***
package seq_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RATE = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  // control register bit positions
  localparam int CTRL_CHOP = 0;
  localparam int CTRL_AZ = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_RINJ = 3;
  // command register bit positions, all self clearing
  localparam int CMD_TRIG = 0;
  localparam int CMD_SAVE = 1;
  localparam int CMD_RECALL = 2;
  localparam int CMD_FACTORY = 3;
  // integration rate codes; only the fast one is shorter than one mains cycle
  localparam logic [1:0] RATE_FAST = 2'h0;
  localparam logic [1:0] RATE_MED = 2'h1;
  localparam logic [1:0] RATE_SLOW = 2'h2;
  // factory default values
  localparam logic CHOP_DEF = 1'b1;
  localparam logic AZ_DEF = 1'b1;
  localparam logic SYNC_DEF = 1'b0;
  localparam logic RINJ_DEF = 1'b0;
  localparam logic [1:0] RATE_DEF = RATE_MED;
  // kind of each converter cycle
  localparam logic [1:0] KIND_SIG = 2'h0;
  localparam logic [1:0] KIND_OFS = 2'h1;
  localparam logic [1:0] KIND_GAIN = 2'h2;
  localparam logic [1:0] KIND_TEMP = 2'h3;
  // bus answers and menu characters
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [7:0] CHAR_Y = 8'h59;
  localparam logic [7:0] CHAR_N = 8'h4e;
  // saved setup word: {rate, rinj, sync, az, chop}
  localparam int CFG_W = 6;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SYNC = 6'b000010,
    ST_SIG = 6'b000100,
    ST_REV = 6'b001000,
    ST_CAL = 6'b010000,
    ST_DONE = 6'b100000
  } seq_state_t;
endpackage : seq_pkg

// *** design/setup_store.sv ***
`timescale 1ns/1ps
// one saved user setup; read data always come from a register
module setup_store #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // write side
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  output logic [WIDTH-1:0] rd_data_q
);
  logic [WIDTH-1:0] mem_q;

  // the slot starts empty-valued; recall before any save gives zeros
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_q <= '0;
    end else if (ce && wr_en) begin
      mem_q <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= '0;
    end else if (ce) begin
      rd_data_q <= mem_q;
    end
  end
endmodule : setup_store

// *** design/zero_cross_gate.sv ***
`timescale 1ns/1ps
// holds a start request until the next mains polarity change
module zero_cross_gate (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // request
  input wire logic arm,
  input wire logic sync_en,
  input wire logic mains_positive,
  // answer
  output logic go_q,
  output logic waiting_q
);
  logic phase_prev_q;
  logic prev_ok_q;
  logic crossing;

  // either direction counts; no crossing until a real sample is held, so reset gives no false edge
  assign crossing = prev_ok_q && (mains_positive != phase_prev_q);

  // track the line polarity every cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_prev_q <= 1'b0;
      prev_ok_q <= 1'b0;
    end else if (ce) begin
      phase_prev_q <= mains_positive;
      prev_ok_q <= 1'b1;
    end
  end

  // positive half arms for the falling edge, negative half for the rising one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      go_q <= 1'b0;
      waiting_q <= 1'b0;
    end else if (ce) begin
      go_q <= 1'b0;
      if (arm) begin
        if (!sync_en || crossing) begin
          go_q <= 1'b1;
        end else begin
          waiting_q <= 1'b1;
        end
      end else if (waiting_q && crossing) begin
        go_q <= 1'b1;
        waiting_q <= 1'b0;
      end
    end
  end

  AST_ZC_GO: assert property (@(posedge clk) disable iff (rst) ce && waiting_q && crossing |=> go_q)
    else $error("start not released at zero crossing");
  AST_ZC_HOLD: assert property (@(posedge clk) disable iff (rst) ce && waiting_q && !crossing |=> !go_q)
    else $error("start released between crossings");
endmodule : zero_cross_gate

// *** design/reading_sequencer.sv ***
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module reading_sequencer import seq_pkg::*; #(
  parameter int CAL_EVERY = 4,
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // front panel
  input wire logic fp_chop_sel,
  input wire logic fp_az_sel,
  input wire logic fp_enter,
  input wire logic fp_rate_req,
  input wire logic [1:0] fp_rate,
  input wire logic fp_factory,
  input wire logic fp_save,
  input wire logic fp_recall,
  output logic [7:0] menu_chop_char,
  output logic menu_az_yes,
  // trigger and mains phase
  input wire logic ext_trigger,
  input wire logic mains_positive,
  // converter
  output logic adc_start,
  output logic [1:0] adc_kind,
  output logic adc_reversed,
  input wire logic adc_done,
  output logic reading_done,
  output logic reduced_injection_mode
);
  seq_state_t state_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go, wr_ctrl, wr_rate, wr_cmd;
  logic factory, recall, save, trig_in;
  logic chop_en_q, az_en_q, sync_en_q, rinj_q;
  logic [1:0] rate_q;
  logic [CFG_W-1:0] cfg_saved;
  logic refresh_q, trig_pend_q;
  logic run_chop_q, run_az_q, run_full_q, conv_busy_q;
  logic [1:0] cal_idx_q, cal_left_q;
  logic [7:0] cal_cnt_q;
  logic [CNT_W-1:0] count_q;
  logic take, zc_go, zc_waiting, sync_eff, cal_due, last_cal;
  logic [31:0] rd_mux;

  // word index of a byte address; low two bits are not decoded
  function automatic logic [5:0] reg_index(input logic [7:0] addr);
    reg_index = addr[7:2];
  endfunction : reg_index

  function automatic logic mapped(input logic [7:0] addr);
    logic [5:0] idx;
    idx = reg_index(addr);
    mapped = idx <= reg_index(OFF_COUNT);
  endfunction : mapped

  // write address and data may arrive in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // only the low byte carries fields, so only its strobe matters
  assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_ctrl = wr_go && wstrb_q[0] && reg_index(awaddr_q) == reg_index(OFF_CTRL);
  assign wr_rate = wr_go && wstrb_q[0] && reg_index(awaddr_q) == reg_index(OFF_RATE);
  assign wr_cmd = wr_go && wstrb_q[0] && reg_index(awaddr_q) == reg_index(OFF_CMD);
  assign factory = fp_factory || (wr_cmd && wdata_q[CMD_FACTORY]);
  assign recall = fp_recall || (wr_cmd && wdata_q[CMD_RECALL]);
  assign save = fp_save || (wr_cmd && wdata_q[CMD_SAVE]);
  assign trig_in = ext_trigger || (wr_cmd && wdata_q[CMD_TRIG]);

  // read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_index(s_axi_araddr) == reg_index(OFF_CTRL)) begin
      rd_mux[CTRL_CHOP] = chop_en_q;
      rd_mux[CTRL_AZ] = az_en_q;
      rd_mux[CTRL_SYNC] = sync_en_q;
      rd_mux[CTRL_RINJ] = rinj_q;
    end else if (reg_index(s_axi_araddr) == reg_index(OFF_RATE)) begin
      rd_mux[1:0] = rate_q;
    end else if (reg_index(s_axi_araddr) == reg_index(OFF_STAT)) begin
      rd_mux[5:0] = state_q;
      rd_mux[8:6] = {refresh_q, trig_pend_q, zc_waiting};
    end else if (reg_index(s_axi_araddr) == reg_index(OFF_COUNT)) begin
      rd_mux[CNT_W-1:0] = count_q;
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  setup_store #(
    .WIDTH(CFG_W)
  ) u_store (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_en(save),
    .wr_data({rate_q, rinj_q, sync_en_q, az_en_q, chop_en_q}),
    .rd_data_q(cfg_saved)
  );

  // settings; factory beats recall beats remote beats panel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chop_en_q <= CHOP_DEF;
      az_en_q <= AZ_DEF;
      sync_en_q <= SYNC_DEF;
      rinj_q <= RINJ_DEF;
      rate_q <= RATE_DEF;
    end else if (ce) begin
      if (factory) begin
        chop_en_q <= CHOP_DEF;
        az_en_q <= AZ_DEF;
        sync_en_q <= SYNC_DEF;
        rinj_q <= RINJ_DEF;
        rate_q <= RATE_DEF;
      end else if (recall) begin
        {rate_q, rinj_q, sync_en_q, az_en_q, chop_en_q} <= cfg_saved;
      end else if (wr_ctrl || wr_rate) begin
        if (wr_ctrl) begin
          chop_en_q <= wdata_q[CTRL_CHOP];
          az_en_q <= wdata_q[CTRL_AZ];
          sync_en_q <= wdata_q[CTRL_SYNC];
          rinj_q <= wdata_q[CTRL_RINJ];
        end
        if (wr_rate) begin
          rate_q <= wdata_q[1:0];
        end
      end else if (fp_enter) begin
        chop_en_q <= fp_chop_sel;
        az_en_q <= fp_az_sel;
      end else if (fp_rate_req) begin
        rate_q <= fp_rate;
        az_en_q <= 1'b1;
      end
    end
  end

  // menu face of the stored settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      menu_chop_char <= CHAR_Y;
      menu_az_yes <= 1'b1;
      reduced_injection_mode <= RINJ_DEF;
    end else if (ce) begin
      menu_chop_char <= chop_en_q ? CHAR_Y : CHAR_N;
      menu_az_yes <= az_en_q;
      reduced_injection_mode <= rinj_q;
    end
  end

  // a panel fast-rate request, or a remote one with autozero on, arms one full refresh; a new request beats the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refresh_q <= 1'b0;
    end else if (ce) begin
      if ((wr_rate && wdata_q[1:0] == RATE_FAST) || (fp_rate_req && fp_rate == RATE_FAST)) begin
        refresh_q <= az_en_q || fp_rate_req;
      end else if (take) begin
        refresh_q <= 1'b0;
      end
    end
  end

  // triggers wait here while a reading is running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_pend_q <= 1'b0;
    end else if (ce) begin
      if (trig_in) begin
        trig_pend_q <= 1'b1;
      end else if (take) begin
        trig_pend_q <= 1'b0;
      end
    end
  end

  assign take = state_q == ST_IDLE && trig_pend_q;
  assign sync_eff = sync_en_q && rate_q != RATE_FAST;
  assign cal_due = run_az_q && (run_full_q || cal_cnt_q == 8'(CAL_EVERY - 1));
  assign last_cal = !run_full_q || cal_left_q == 2'h0;

  zero_cross_gate u_zc (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .arm(take),
    .sync_en(sync_eff),
    .mains_positive(mains_positive),
    .go_q(zc_go),
    .waiting_q(zc_waiting)
  );

  // settings are frozen per reading when the pending trigger is taken in idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_chop_q <= CHOP_DEF;
      run_az_q <= AZ_DEF;
      run_full_q <= 1'b0;
    end else if (ce && take) begin
      run_chop_q <= chop_en_q;
      run_az_q <= az_en_q;
      run_full_q <= az_en_q && refresh_q;
    end
  end

  // reading sequence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      adc_start <= 1'b0;
      adc_kind <= KIND_SIG;
      adc_reversed <= 1'b0;
      reading_done <= 1'b0;
    end else if (ce) begin
      adc_start <= 1'b0;
      reading_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (zc_go) begin
            state_q <= ST_SIG;
            adc_start <= 1'b1;
            adc_kind <= KIND_SIG;
            adc_reversed <= 1'b0;
          end
        end
        ST_SIG: begin
          if (adc_done) begin
            adc_start <= run_chop_q || cal_due;
            if (run_chop_q) begin
              state_q <= ST_REV;
              adc_reversed <= 1'b1;
            end else if (cal_due) begin
              state_q <= ST_CAL;
              adc_kind <= KIND_OFS + cal_idx_q;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_REV: begin
          if (adc_done) begin
            adc_reversed <= 1'b0;
            adc_start <= cal_due;
            adc_kind <= KIND_OFS + cal_idx_q;
            state_q <= cal_due ? ST_CAL : ST_DONE;
          end
        end
        ST_CAL: begin
          if (adc_done) begin
            adc_start <= !last_cal;
            adc_kind <= KIND_OFS + ((cal_idx_q == 2'h2) ? 2'h0 : cal_idx_q + 2'h1);
            state_q <= last_cal ? ST_DONE : ST_CAL;
          end
        end
        ST_DONE: begin
          reading_done <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // calibration bookkeeping: one reference point per period keeps refresh gradual
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_idx_q <= 2'h0;
      cal_left_q <= 2'h2;
      cal_cnt_q <= 8'h00;
    end else if (ce) begin
      if (take) begin
        cal_left_q <= 2'h2;
      end else if (state_q == ST_CAL && adc_done) begin
        cal_idx_q <= (cal_idx_q == 2'h2) ? 2'h0 : cal_idx_q + 2'h1;
        cal_left_q <= cal_left_q - 2'h1;
      end
      if (state_q == ST_DONE && run_az_q) begin
        cal_cnt_q <= (cal_cnt_q == 8'(CAL_EVERY - 1) || run_full_q) ? 8'h00 : cal_cnt_q + 8'h01;
      end
    end
  end

  // outstanding conversion and reading count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_busy_q <= 1'b0;
      count_q <= '0;
    end else if (ce) begin
      if (adc_start) begin
        conv_busy_q <= 1'b1;
      end else if (adc_done) begin
        conv_busy_q <= 1'b0;
      end
      if (reading_done) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  AST_CHOP_REV: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == ST_SIG && adc_done && run_chop_q |=> adc_start && adc_reversed && adc_kind == KIND_SIG)
    else $error("reversed cycle missing");
  AST_NO_REV: assert property (@(posedge clk) disable iff (rst) adc_start && !run_chop_q |-> !adc_reversed)
    else $error("reversed cycle with chop off");
  AST_CAL_ONLY_AZ: assert property (@(posedge clk) disable iff (rst) adc_start && adc_kind != KIND_SIG |-> run_az_q)
    else $error("calibration cycle with autozero off");
  AST_CAL_DUE: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == ST_SIG && adc_done && !run_chop_q && cal_due |=> adc_start && adc_kind != KIND_SIG)
    else $error("calibration cycle skipped");
  AST_GRADUAL: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == ST_CAL && adc_done && !run_full_q |=> state_q == ST_DONE)
    else $error("more than one calibration cycle");
  AST_FACTORY: assert property (@(posedge clk) disable iff (rst)
    ce && factory |=> chop_en_q && az_en_q && !sync_en_q && !rinj_q)
    else $error("factory values not applied");
  AST_FP_RATE: assert property (@(posedge clk) disable iff (rst)
    ce && fp_rate_req && !factory && !recall && !wr_ctrl && !wr_rate && !fp_enter |=> az_en_q)
    else $error("panel rate did not enable autozero");
  AST_REMOTE_RATE: assert property (@(posedge clk) disable iff (rst)
    ce && wr_rate && !wr_ctrl && !factory && !recall |=> $stable(az_en_q))
    else $error("remote rate changed autozero");
  AST_REFRESH: assert property (@(posedge clk) disable iff (rst)
    ce && wr_rate && wdata_q[1:0] == RATE_FAST && az_en_q |=> refresh_q)
    else $error("fast rate did not arm refresh");
  AST_SUB_PLC: assert property (@(posedge clk) disable iff (rst)
    ce && take && rate_q == RATE_FAST |=> zc_go)
    else $error("sync applied below one mains cycle");
  AST_ENTER: assert property (@(posedge clk) disable iff (rst)
    ce && fp_enter && !factory && !recall && !wr_ctrl && !wr_rate |=> chop_en_q == $past(fp_chop_sel))
    else $error("enter did not commit");
  AST_RINJ_SRC: assert property (@(posedge clk) disable iff (rst)
    $changed(rinj_q) |-> $past(wr_ctrl || factory || recall))
    else $error("injection mode changed from panel");
  AST_DONE_LAST: assert property (@(posedge clk) disable iff (rst) reading_done |-> !conv_busy_q)
    else $error("reading done with a cycle open");
  AST_FROZEN: assert property (@(posedge clk) disable iff (rst)
    ce && state_q != ST_IDLE |=> $stable(run_chop_q) && $stable(run_az_q))
    else $error("settings changed mid reading");
  COV_CHOP_CAL: cover property (@(posedge clk) disable iff (rst) state_q == ST_REV ##1 state_q == ST_CAL);
  COV_FULL: cover property (@(posedge clk) disable iff (rst) run_full_q && state_q == ST_CAL && adc_done && !last_cal);
  COV_SYNC_WAIT: cover property (@(posedge clk) disable iff (rst) zc_waiting ##1 zc_go);
endmodule : reading_sequencer

// *** bench/adc_model.sv ***
`timescale 1ns/1ps
// converter and mains-phase stand-in for the sequencer's far side
module adc_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // converter handshake
  input wire logic adc_start,
  input wire logic [7:0] adc_delay,
  output logic adc_done,
  // mains phase, free running square wave
  output logic mains_positive
);
  logic [7:0] cnt_q;
  logic [5:0] ph_q;
  // one conversion at a time; done pulses adc_delay cycles after the start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      adc_done <= 1'b0;
    end else begin
      adc_done <= (cnt_q == 8'h01);
      if (adc_start) begin
        cnt_q <= adc_delay;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  // half period of 37 cycles, so crossings drift against the bus timing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_q <= 6'h00;
      mains_positive <= 1'b1;
    end else if (ph_q == 6'h24) begin
      ph_q <= 6'h00;
      mains_positive <= ~mains_positive;
    end else begin
      ph_q <= ph_q + 6'h01;
    end
  end
endmodule : adc_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import seq_pkg::*;
  logic clk, rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fp_chop_sel, fp_az_sel, fp_enter;
  logic fp_rate_req, fp_factory, fp_save, fp_recall, menu_az_yes, ext_trigger, mains_positive;
  logic adc_start, adc_reversed, adc_done, reading_done, reduced_injection_mode, mains_d, arm;
  logic [7:0] s_axi_awaddr, s_axi_araddr, menu_chop_char, adc_delay;
  logic [31:0] s_axi_wdata, s_axi_rdata, got;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, fp_rate, adc_kind, resp;
  int err_count, comparisons, cyc, last_chg, first_st, gap, t0, n_st, n_rev, n_cal, s, c;
  // rows: control word, rate, starts, reversed starts, sync expected
  logic [3:0] r_ctrl [5] = '{4'h1, 4'h0, 4'h5, 4'h4, 4'h0};
  logic [1:0] r_rate [5] = '{RATE_MED, RATE_MED, RATE_MED, RATE_FAST, RATE_SLOW};
  int r_st [5] = '{2, 1, 2, 1, 1};
  int r_rev [5] = '{1, 0, 1, 0, 0};
  logic r_sync [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  reading_sequencer u_dut (.*);
  adc_model u_adc (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // converter activity counters; arm marks the first start of a reading
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mains_d <= mains_positive;
    if (mains_positive !== mains_d) last_chg <= cyc;
    if (adc_start === 1'b1) begin
      n_st <= n_st + 1;
      n_rev <= n_rev + int'(adc_reversed);
      n_cal <= n_cal + int'(adc_kind !== KIND_SIG);
      if (arm) begin
        first_st <= cyc;
        gap <= cyc - last_chg;
        arm <= 1'b0;
      end
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (exp !== seen) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask : check

  task automatic results;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task automatic hang;
    $display("ERROR wait expected answer seen none");
    err_count++;
    results();
  endtask : hang

  // write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200) hang();
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200) hang();
  endtask : axr

  // one triggered reading; a negative expectation skips that count
  task automatic reading(input int est, input int erev, input logic sync);
    int n, s0, v0;
    n = 0;
    s0 = n_st;
    v0 = n_rev;
    @(posedge clk);
    ext_trigger <= 1'b1;
    arm <= 1'b1;
    t0 = cyc;
    @(posedge clk);
    ext_trigger <= 1'b0;
    while (reading_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) hang();
    @(posedge clk);
    if (est >= 0) check("starts", est, n_st - s0);
    if (erev >= 0) check("reversed", erev, n_rev - v0);
    if (sync) check("crossing gap", 1, gap <= 3);
    else check("start latency", 1, first_st - t0 <= 7);
  endtask : reading

  initial begin
    {ce, s_axi_wstrb, rst} = {1'b1, 4'hf, 1'b1};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fp_rate, fp_save, fp_recall} = '0;
    {fp_chop_sel, fp_az_sel, fp_enter, fp_rate_req, fp_factory, ext_trigger} = '0;
    {cyc, last_chg, first_st, gap, n_st, n_rev, n_cal, arm, mains_d} = '0;
    {err_count, comparisons, adc_delay} = {32'h0, 32'h0, 8'h03};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    axr(OFF_CTRL);
    check("ctrl reset", 32'h3, got);
    check("menu reset", {CHAR_Y, 1'b1, 1'b0}, {menu_chop_char, menu_az_yes, reduced_injection_mode});
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      axw(OFF_CTRL, {28'h0, r_ctrl[i]});
      axw(OFF_RATE, {30'h0, r_rate[i]});
      reading(r_st[i], r_rev[i], r_sync[i]);
    end
    $display("row tests done");
    axw(OFF_CTRL, 32'h2);
    adc_delay <= 8'h28;
    {s, c} = {n_st, n_cal};
    repeat (4) reading(-1, 0, 1'b0);
    check("periodic cal", 32'h1, n_cal - c);
    check("az starts", 32'h5, n_st - s);
    axw(OFF_RATE, {30'h0, RATE_FAST});
    axw(OFF_RATE, {30'h0, RATE_MED});
    c = n_cal;
    reading(-1, 0, 1'b0);
    check("refresh", 32'h1, n_cal - c >= 3);
    $display("autozero tests done");
    axw(OFF_CTRL, 32'h1);
    fork
      reading(2, 1, 1'b0);
      begin
        repeat (12) @(posedge clk);
        axw(OFF_CTRL, 32'h0);
      end
    join
    reading(1, 0, 1'b0);
    axw(OFF_RATE, {30'h0, RATE_SLOW});
    axr(OFF_CTRL);
    check("remote rate", 32'h0, got);
    @(posedge clk);
    fp_rate <= RATE_FAST;
    fp_rate_req <= 1'b1;
    @(posedge clk);
    fp_rate_req <= 1'b0;
    axr(OFF_CTRL);
    check("panel rate", 32'h2, got);
    @(posedge clk);
    fp_enter <= 1'b1;
    @(posedge clk);
    fp_enter <= 1'b0;
    fp_chop_sel <= 1'b1;
    repeat (3) @(posedge clk);
    check("menu", {CHAR_N, 1'b0}, {menu_chop_char, menu_az_yes});
    axr(OFF_CTRL);
    check("menu commit", 32'h0, got);
    axw(OFF_CTRL, 32'hc);
    @(posedge clk);
    check("rinj on", 32'h1, reduced_injection_mode);
    axw(OFF_CMD, 32'h2);
    @(posedge clk);
    fp_factory <= 1'b1;
    @(posedge clk);
    fp_factory <= 1'b0;
    axr(OFF_CTRL);
    check("factory", 32'h3, got);
    check("rinj off", 32'h0, reduced_injection_mode);
    axw(OFF_CMD, 32'h4);
    axr(OFF_CTRL);
    check("recall", 32'hc, got);
    axw(8'h14, 32'h1);
    check("unmapped write", RESP_SLVERR, resp);
    axr(8'h14);
    check("unmapped read", RESP_SLVERR, resp);
    check("unmapped data", 32'h0, got);
    $display("setting tests done");
    results();
  end

  initial begin
    repeat (90000) @(posedge clk);
    hang();
  end
endmodule : tb_top
